// [rtc_irq_pkg.sv]
package rtc_irq_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] flag_reg_off = 8'h38;
   localparam logic [7:0] ctrl_reg_off = 8'h3c;
   localparam logic [7:0] osc_trim_off = 8'h2c;
   localparam logic [7:0] irq_stat_off = 8'h40;
   localparam logic [7:0] irq_mask_off = 8'h44;
   localparam logic [7:0] clk_stat_off = 8'h48;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int update_bit = 5;
   localparam int timer_bit = 4;
   localparam int alarm_bit = 3;
   localparam int event_bit = 2;
   localparam int clk_reset_bit = 0;
   localparam int trim_msb = 3;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] ctrl_reset_val = 8'h00;
   localparam logic [3:0] trim_reset_val = 4'h0;
   localparam logic [3:0] mask_reset_val = 4'h0;

   // ****************************************
   // Timing
   // ****************************************
   localparam int clk_period_ps = 10000;
   localparam longint release_time_ps = 64'd7800000000;
   localparam int release_cycles = int'(release_time_ps / clk_period_ps);

   // Event set: bit 3 update, 2 timer, 1 alarm, 0 event
   typedef struct packed {
      logic update;
      logic timer;
      logic alarm;
      logic ev;
   } src_vec_t;

endpackage

// [release_timer.sv]
`timescale 1ns/1ps
module release_timer #(
   parameter int cycles = 780000
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic cancel,
   output logic active
);

   logic [31:0] count_ff;

   // Restart on each event; drop on cancel or on expiry
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_ff <= 32'h0;
         active <= 1'b0;
      end else if (start) begin
         count_ff <= 32'(cycles - 1);
         active <= 1'b1;
      end else if (cancel || count_ff == 32'h0) begin
         count_ff <= 32'h0;
         active <= 1'b0;
      end else begin
         count_ff <= count_ff - 32'h1;
      end
   end

endmodule

// [sync2.sv]
`timescale 1ns/1ps
module sync2 (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic d,
   output logic q
);

   logic meta_ff;

   // First stage is read only by the second
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end

endmodule

// [rtc_irq_enable_and_osc_trim.sv]
// Overview of operation
// - Update flag rising drives pin low only when update enable is set.
// - Clearing update, timer or alarm enable cancels that source's low.
// - Update-caused low releases itself 7.8 ms after the event.
// - Timer flag rising drives pin low only when timer enable is set.
// - Timer-caused low releases itself within 7.8 ms.
// - Alarm flag rising drives pin low only when alarm enable is set.
// - Alarm low has no auto release; held until flag or enable cleared.
// - Pin is OR of all enabled active sources.
// - With enables off, pin stays released but flags still set.
// - Event flag rising drives pin low only when event enable is set.
// - Clock reset bit clears sub-second counter and halts timekeeping.
// - Stopped state ends when host drives select line low.
// - Four-bit trim code selects offset; upper bits read zero.
// - Flags set by events, cleared by writing zero; writing one ignored.
// - Enables at control bits 5..2, clock reset at bit 0.
`timescale 1ns/1ps
module rtc_irq_enable_and_osc_trim #(
   parameter int release_len = rtc_irq_pkg::release_cycles
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic update_event,
   input wire logic timer_event,
   input wire logic alarm_event,
   input wire logic event_event,
   input wire logic select_line,
   input wire logic irq_line_n_in,
   output logic irq_line_n_out,
   output logic irq_line_n_oe,
   output logic subsec_clear,
   output logic clock_halt,
   output logic [3:0] osc_trim_code,
   output logic irq
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   rtc_irq_pkg::src_vec_t ev_sync;
   logic sel_sync;
   logic [3:0] ev_raw;
   logic [3:0] ev_q;

   assign ev_raw = {update_event, timer_event, alarm_event, event_event};
   assign ev_sync = ev_q;

   // One synchroniser per event source, same bit order as the struct
   for (genvar i = 0; i < 4; i++) begin : g_ev_sync
      sync2 u_sync (.ref_clk(ref_clk), .reset_n(reset_n),
         .d(ev_raw[i]), .q(ev_q[i]));
   end
   sync2 u_s_sel (.ref_clk(ref_clk), .reset_n(reset_n),
      .d(select_line), .q(sel_sync));

   // Pin read-back not needed: open drain, our own drive is known
   logic pin_unused;
   assign pin_unused = irq_line_n_in;

   // ****************************************
   // Event edge detection
   // ****************************************
   rtc_irq_pkg::src_vec_t ev_prev_ff;
   rtc_irq_pkg::src_vec_t ev_pulse;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ev_prev_ff <= '0;
      end else begin
         ev_prev_ff <= ev_sync;
      end
   end

   assign ev_pulse = ev_sync & ~ev_prev_ff;

   // ****************************************
   // Bus decode
   // ****************************************
   logic wr_flag, wr_ctrl, wr_trim, wr_stat, wr_mask;
   logic wr_lane0;

   assign wr_lane0 = avs_write && avs_byteenable[0] && !avs_waitrequest;
   assign wr_flag = wr_lane0 && avs_address == rtc_irq_pkg::flag_reg_off;
   assign wr_ctrl = wr_lane0 && avs_address == rtc_irq_pkg::ctrl_reg_off;
   assign wr_trim = wr_lane0 && avs_address == rtc_irq_pkg::osc_trim_off;
   assign wr_stat = wr_lane0 && avs_address == rtc_irq_pkg::irq_stat_off;
   assign wr_mask = wr_lane0 && avs_address == rtc_irq_pkg::irq_mask_off;

   // One wait cycle, then accept
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // ****************************************
   // Control register
   // ****************************************
   rtc_irq_pkg::src_vec_t en_ff;
   logic clk_reset_ff;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         en_ff <= '0;
      end else if (wr_ctrl) begin
         en_ff.update <= avs_writedata[rtc_irq_pkg::update_bit];
         en_ff.timer <= avs_writedata[rtc_irq_pkg::timer_bit];
         en_ff.alarm <= avs_writedata[rtc_irq_pkg::alarm_bit];
         en_ff.ev <= avs_writedata[rtc_irq_pkg::event_bit];
      end
   end

   // Select low wins over a simultaneous write of one
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_reset_ff <= rtc_irq_pkg::ctrl_reset_val[0];
      end else if (!sel_sync) begin
         clk_reset_ff <= 1'b0;
      end else if (wr_ctrl && avs_writedata[rtc_irq_pkg::clk_reset_bit]) begin
         clk_reset_ff <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         subsec_clear <= 1'b0;
         clock_halt <= 1'b0;
      end else begin
         subsec_clear <= clk_reset_ff;
         clock_halt <= clk_reset_ff;
      end
   end

   // ****************************************
   // Oscillator trim
   // ****************************************
   // Code 0 none, 1..7 negative, 8 largest positive down to 15
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_trim_code <= rtc_irq_pkg::trim_reset_val;
      end else if (wr_trim) begin
         osc_trim_code <= avs_writedata[rtc_irq_pkg::trim_msb:0];
      end
   end

   // ****************************************
   // Event flags
   // ****************************************
   rtc_irq_pkg::src_vec_t flag_ff;
   rtc_irq_pkg::src_vec_t flag_wr;
   rtc_irq_pkg::src_vec_t flag_clr;

   assign flag_wr = {avs_writedata[rtc_irq_pkg::update_bit],
                     avs_writedata[rtc_irq_pkg::timer_bit],
                     avs_writedata[rtc_irq_pkg::alarm_bit],
                     avs_writedata[rtc_irq_pkg::event_bit]};
   assign flag_clr = wr_flag ? ~flag_wr : '0;

   // Set wins over clear; writing one leaves a flag alone
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_ff <= '0;
      end else begin
         flag_ff <= ev_pulse | (flag_ff & ~flag_clr);
      end
   end

   // Flag rising edges, one per source
   rtc_irq_pkg::src_vec_t flag_prev_ff;
   rtc_irq_pkg::src_vec_t flag_rise;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_prev_ff <= '0;
      end else begin
         flag_prev_ff <= flag_ff;
      end
   end

   assign flag_rise = flag_ff & ~flag_prev_ff;

   // ****************************************
   // Per-source pin drive
   // ****************************************
   logic upd_active, tmr_active;
   rtc_irq_pkg::src_vec_t src_low;

   // Window length is a parameter so a bench can shorten it
   // Update: latched on rise if enabled, self-releases after window
   release_timer #(.cycles(release_len)) u_rel_upd (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .start(flag_rise.update && en_ff.update),
      .cancel(!en_ff.update || !flag_ff.update),
      .active(upd_active)
   );

   // Timer: same window; expiry is the latest release point
   release_timer #(.cycles(release_len)) u_rel_tmr (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .start(flag_rise.timer && en_ff.timer),
      .cancel(!en_ff.timer || !flag_ff.timer),
      .active(tmr_active)
   );

   // Alarm and event hold until flag or enable is cleared
   logic alm_hold_ff, evt_hold_ff;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         alm_hold_ff <= 1'b0;
      end else if (flag_rise.alarm && en_ff.alarm) begin
         alm_hold_ff <= 1'b1;
      end else if (!flag_ff.alarm || !en_ff.alarm) begin
         alm_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         evt_hold_ff <= 1'b0;
      end else if (flag_rise.ev && en_ff.ev) begin
         evt_hold_ff <= 1'b1;
      end else if (!flag_ff.ev || !en_ff.ev) begin
         evt_hold_ff <= 1'b0;
      end
   end

   // Gate with live enable so a cleared enable drops at once
   assign src_low = {upd_active && en_ff.update,
                     tmr_active && en_ff.timer,
                     alm_hold_ff && en_ff.alarm,
                     evt_hold_ff && en_ff.ev};

   // Output value fixed low; only the enable moves
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_line_n_oe <= 1'b0;
      end else begin
         irq_line_n_oe <= |src_low;
      end
   end

   assign irq_line_n_out = 1'b0;

   // ****************************************
   // Sticky status, mask, interrupt line
   // ****************************************
   rtc_irq_pkg::src_vec_t stat_ff;
   rtc_irq_pkg::src_vec_t mask_ff;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         stat_ff <= '0;
      end else if (wr_stat) begin
         stat_ff <= ev_pulse | (stat_ff & ~rtc_irq_pkg::src_vec_t'(
                    avs_writedata[3:0]));
      end else begin
         stat_ff <= stat_ff | ev_pulse;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mask_ff <= rtc_irq_pkg::mask_reset_val;
      end else if (wr_mask) begin
         mask_ff <= avs_writedata[3:0];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_ff & mask_ff);
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   logic [31:0] nxt_rdata;

   always_comb begin
      nxt_rdata = 32'h0;
      unique case (avs_address)
         rtc_irq_pkg::flag_reg_off: begin
            nxt_rdata[rtc_irq_pkg::update_bit] = flag_ff.update;
            nxt_rdata[rtc_irq_pkg::timer_bit] = flag_ff.timer;
            nxt_rdata[rtc_irq_pkg::alarm_bit] = flag_ff.alarm;
            nxt_rdata[rtc_irq_pkg::event_bit] = flag_ff.ev;
         end
         rtc_irq_pkg::ctrl_reg_off: begin
            nxt_rdata[rtc_irq_pkg::update_bit] = en_ff.update;
            nxt_rdata[rtc_irq_pkg::timer_bit] = en_ff.timer;
            nxt_rdata[rtc_irq_pkg::alarm_bit] = en_ff.alarm;
            nxt_rdata[rtc_irq_pkg::event_bit] = en_ff.ev;
            nxt_rdata[rtc_irq_pkg::clk_reset_bit] = clk_reset_ff;
         end
         rtc_irq_pkg::osc_trim_off: begin
            nxt_rdata[3:0] = osc_trim_code;
         end
         rtc_irq_pkg::irq_stat_off: begin
            nxt_rdata[3:0] = stat_ff;
         end
         rtc_irq_pkg::irq_mask_off: begin
            nxt_rdata[3:0] = mask_ff;
         end
         rtc_irq_pkg::clk_stat_off: begin
            nxt_rdata[3:0] = src_low;
         end
         default: begin
            nxt_rdata = 32'h0;
         end
      endcase
   end

   // Unmapped reads return zero, writes are dropped
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= nxt_rdata;
      end
   end

endmodule

// [rtc_irq_checker_assertions.sv]
`timescale 1ns/1ps
module rtc_irq_checker (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic update_event,
   input wire logic timer_event,
   input wire logic alarm_event,
   input wire logic event_event,
   input wire logic select_line,
   input wire logic irq_line_n_out,
   input wire logic irq_line_n_oe,
   input wire logic subsec_clear,
   input wire logic clock_halt,
   input wire logic [3:0] osc_trim_code
);
   // ****
   // Helpers
   // ****
   logic ev_any;
   logic take_wr;
   logic halt_wr;
   logic trim_wr;
   assign ev_any = update_event | timer_event | alarm_event | event_event;
   assign take_wr = avs_write & ~avs_waitrequest;
   assign halt_wr = take_wr & avs_writedata[0]
      & (avs_address == rtc_irq_pkg::ctrl_reg_off);
   assign trim_wr = take_wr & (avs_address == rtc_irq_pkg::osc_trim_off);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   property p_drive_low;
      irq_line_n_oe |-> irq_line_n_out == 1'b0;
   endproperty
   a_drive_low: assert property (p_drive_low)
      else $error("pin driven high");
   property p_wait_one;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("bus answer late");
   property p_wait_idle;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_idle: assert property (p_wait_idle)
      else $error("wait dropped twice");
   property p_halt_pair;
      subsec_clear == clock_halt;
   endproperty
   a_halt_pair: assert property (p_halt_pair)
      else $error("halt and clear differ");
   property p_halt_cause;
      $rose(clock_halt) |-> $past(halt_wr, 1) || $past(halt_wr, 2);
   endproperty
   a_halt_cause: assert property (p_halt_cause)
      else $error("halt without write");
   property p_halt_release;
      !select_line [*5] |-> !clock_halt;
   endproperty
   a_halt_release: assert property (p_halt_release)
      else $error("halt held with select low");
   property p_trim_cause;
      $changed(osc_trim_code) |-> $past(trim_wr, 1) || $past(trim_wr, 2);
   endproperty
   a_trim_cause: assert property (p_trim_cause)
      else $error("trim changed without write");
   // Events are held long by the host, so cause is still visible
   property p_oe_cause;
      $rose(irq_line_n_oe) |-> ev_any || $past(ev_any, 6);
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("pin low without event");
   c_pin_low: cover property ($rose(irq_line_n_oe));
   c_pin_free: cover property ($fell(irq_line_n_oe));
   c_halt: cover property ($rose(clock_halt));
endmodule
bind rtc_irq_enable_and_osc_trim rtc_irq_checker u_chk (
   .ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .update_event(update_event), .timer_event(timer_event),
   .alarm_event(alarm_event), .event_event(event_event),
   .select_line(select_line), .irq_line_n_out(irq_line_n_out),
   .irq_line_n_oe(irq_line_n_oe), .subsec_clear(subsec_clear),
   .clock_halt(clock_halt), .osc_trim_code(osc_trim_code));

// [irq_host_model.sv]
`timescale 1ns/1ps
module irq_host_model (
   input wire logic irq_line_n_out,
   input wire logic irq_line_n_oe,
   output wire logic irq_pin,
   output logic high_seen
);
   // Board pull-up: a released line reads high
   assign irq_pin = irq_line_n_oe ? irq_line_n_out : 1'b1;
   initial begin
      high_seen = 1'b0;
      forever begin
         @(irq_line_n_out or irq_line_n_oe);
         if (irq_line_n_oe === 1'b1 && irq_line_n_out !== 1'b0) begin
            high_seen = 1'b1;
         end
      end
   end
endmodule

// [rtc_irq_enable_and_osc_trim_tb_top.sv]
`timescale 1ns/1ps
module rtc_irq_enable_and_osc_trim_tb_top;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [3:0] ev = 4'h0;
   logic select_line = 1'b1;
   logic irq_line_n_out, irq_line_n_oe, subsec_clear, clock_halt, irq;
   logic [3:0] osc_trim_code;
   wire logic irq_pin;
   logic high_seen;
   logic low_seen = 1'b0;
   int error_cnt = 0;
   int num_checks = 0;
   // Short release window so the auto release fits in the run
   localparam int rel_len = 400;
   always #5 ref_clk = ~ref_clk;
   rtc_irq_enable_and_osc_trim #(.release_len(rel_len)) uut (
      .ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .update_event(ev[3]), .timer_event(ev[2]), .alarm_event(ev[1]),
      .event_event(ev[0]), .select_line(select_line),
      .irq_line_n_in(irq_pin), .irq_line_n_out(irq_line_n_out),
      .irq_line_n_oe(irq_line_n_oe), .subsec_clear(subsec_clear),
      .clock_halt(clock_halt), .osc_trim_code(osc_trim_code), .irq(irq));
   irq_host_model host (.irq_line_n_out(irq_line_n_out),
      .irq_line_n_oe(irq_line_n_oe), .irq_pin(irq_pin),
      .high_seen(high_seen));
   always @(negedge irq_pin) low_seen = 1'b1;
   // ****
   // Tasks
   // ****
   task automatic report_and_stop;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic is_wr, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= is_wr;
      avs_read <= ~is_wr;
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Event held well past the sync and edge stages
   task automatic fire(input int i);
      ev[i] <= 1'b1;
      cyc(12);
      ev[i] <= 1'b0;
      cyc(4);
   endtask
   // ****
   // Tests
   // ****
   initial begin
      cyc(10000);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      cyc(20);
      reset_n <= 1'b1;
      cyc(1);
      rd_chk(rtc_irq_pkg::ctrl_reg_off, 32'h0);
      rd_chk(rtc_irq_pkg::osc_trim_off, 32'h0);
      rd_chk(rtc_irq_pkg::irq_mask_off, 32'h0);
      wr(rtc_irq_pkg::irq_mask_off, 32'hf);
      for (int i = 0; i < 4; i++) fire(i);
      chk(low_seen, 1'b0);
      chk(irq, 1'b1);
      rd_chk(rtc_irq_pkg::flag_reg_off, 32'h3c);
      rd_chk(rtc_irq_pkg::irq_stat_off, 32'hf);
      wr(rtc_irq_pkg::flag_reg_off, 32'h3c);
      rd_chk(rtc_irq_pkg::flag_reg_off, 32'h3c);
      wr(rtc_irq_pkg::irq_mask_off, 32'h0);
      cyc(2);
      chk(irq, 1'b0);
      wr(rtc_irq_pkg::irq_stat_off, 32'hf);
      rd_chk(rtc_irq_pkg::irq_stat_off, 32'h0);
      wr(rtc_irq_pkg::flag_reg_off, 32'h0);
      rd_chk(rtc_irq_pkg::flag_reg_off, 32'h0);
      // Pin held low well inside the window, then cancelled
      for (int i = 0; i < 4; i++) begin
         wr(rtc_irq_pkg::ctrl_reg_off, 32'h1 << (i + 2));
         fire(i);
         chk(irq_pin, 1'b0);
         rd_chk(rtc_irq_pkg::flag_reg_off, 32'h1 << (i + 2));
         cyc(300);
         chk(irq_pin, 1'b0);
         if (i == 1) wr(rtc_irq_pkg::flag_reg_off, 32'h0);
         else wr(rtc_irq_pkg::ctrl_reg_off, 32'h0);
         cyc(3);
         chk(irq_pin, 1'b1);
         wr(rtc_irq_pkg::flag_reg_off, 32'h0);
      end
      // Update and timer lows end by themselves after the window
      for (int i = 2; i < 4; i++) begin
         wr(rtc_irq_pkg::ctrl_reg_off, 32'h1 << (i + 2));
         fire(i);
         cyc(rel_len - 60);
         chk(irq_pin, 1'b0);
         cyc(80);
         chk(irq_pin, 1'b1);
         rd_chk(rtc_irq_pkg::flag_reg_off, 32'h1 << (i + 2));
         wr(rtc_irq_pkg::flag_reg_off, 32'h0);
      end
      wr(rtc_irq_pkg::ctrl_reg_off, 32'h0c);
      fire(1);
      fire(0);
      wr(rtc_irq_pkg::flag_reg_off, 32'h04);
      cyc(3);
      chk(irq_pin, 1'b0);
      wr(rtc_irq_pkg::flag_reg_off, 32'h0);
      cyc(3);
      chk(irq_pin, 1'b1);
      wr(rtc_irq_pkg::ctrl_reg_off, 32'h0);
      for (int c = 0; c < 16; c++) begin
         wr(rtc_irq_pkg::osc_trim_off, 32'hf0 | c);
         rd_chk(rtc_irq_pkg::osc_trim_off, c);
         chk(osc_trim_code, c);
      end
      avs_byteenable <= 4'he;
      wr(rtc_irq_pkg::osc_trim_off, 32'h5);
      avs_byteenable <= 4'hf;
      rd_chk(rtc_irq_pkg::osc_trim_off, 32'hf);
      wr(rtc_irq_pkg::ctrl_reg_off, 32'h01);
      cyc(2);
      chk(clock_halt, 1'b1);
      chk(subsec_clear, 1'b1);
      rd_chk(rtc_irq_pkg::ctrl_reg_off, 32'h01);
      select_line <= 1'b0;
      cyc(6);
      chk(clock_halt, 1'b0);
      rd_chk(rtc_irq_pkg::ctrl_reg_off, 32'h0);
      select_line <= 1'b1;
      wr(8'h10, 32'hff);
      rd_chk(8'h10, 32'h0);
      chk(high_seen, 1'b0);
      report_and_stop();
   end
endmodule
